// [bench/ppm_pad_model.sv]
// Pad and outside-circuit model for the forty port pins.
`timescale 1ns/1ps
`default_nettype none
module ppm_pad_model (
    // Clock
    input  wire logic        clock,
    // Device drive
    input  wire logic [39:0] pad_out,
    input  wire logic [39:0] pad_oe_n,
    input  wire logic [39:0] pad_weak_pu,
    input  wire logic [39:0] pad_very_weak_pu,
    // Outside drive
    input  wire logic [39:0] ext_en,
    input  wire logic [39:0] ext_val,
    // Pin level
    output logic [39:0]      pad_in
);
    logic [39:0] float_r = 40'h55_5555_5555;
    logic [39:0] pu;
    // An undriven pin toggles, so a missing pull-up never reads as a lucky constant.
    always_ff @(posedge clock) begin
        float_r <= ~float_r;
    end
    assign pu = pad_weak_pu | pad_very_weak_pu;
    // Outside drivers overpower pull-ups; the bench keeps wake pins driven.
    assign pad_in = (ext_en & ext_val)
        | (~ext_en & ((~pad_oe_n & pad_out) | (pad_oe_n & (pu | float_r))));
endmodule : ppm_pad_model
`default_nettype wire

// [bench/tb.sv]
// Self-checking testbench for the port pin mode control block.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic                  clock = 0;
    logic                  nrst = 0;
    ppm_pkg::ppm_sfr_req_t req = '0;
    logic                  fuse = 1;
    logic                  gdis = 0;
    logic                  pd = 0;
    logic [7:0]            kbe = '0;
    logic                  osc1 = 1;
    logic                  rc = 0;
    logic                  osc2 = 0;
    logic [39:0]           ext_en = '0;
    logic [39:0]           ext_val = '0;
    logic [39:0]           alt_in, pin, p_out, p_oen, p_wk, p_vw, p_ib, gfree;
    logic [7:0]            rdata, v;
    logic [5:0]            gcnt;
    logic                  rd_d = 0;
    logic                  hit;
    logic [39:0]           alt = '1;
    logic [7:0]            expq[$];
    logic [31:0]           lfsr = 32'h43b5;
    int                    failures = 0;
    int                    compares = 0;
    logic [7:0] ra[10] = '{8'hd4, 8'hd5, 8'he6, 8'he7, 8'hd6, 8'hd7, 8'hde, 8'hcf, 8'hbe, 8'hbf};
    logic [7:0] r1[10] = '{8'hff, 8'hff, 8'hff, 8'h00, 8'hff, 8'h00, 8'hff, 8'h00, 8'hc7, 8'h03};
    logic [7:0] r0[10] = '{8'hff, 8'hff, 8'h00, 8'h00, 8'hf0, 8'h00, 8'h00, 8'h00, 8'h03, 8'h03};
    // Pin 10 per {select a, select b, latch}: {drive high, oe_n, weak, very weak}.
    logic [3:0] mx[8] = '{4'h0, 4'h7, 4'h0, 4'h8, 4'h4, 4'h4, 4'h0, 4'h4};
    always #12.5 clock = ~clock;
    ppm_port_ctrl u_dut (.clock(clock), .nrst(nrst), .sfr_req(req), .sfr_rdata(rdata),
        .sfr_hit(hit), .tristate_fuse(fuse), .pullup_global_disable(gdis), .power_down(pd),
        .keyboard_enable(kbe), .first_osc_enable(osc1), .first_osc_rc_mode(rc),
        .second_osc_enable(osc2), .alt_out(alt), .alt_in(alt_in), .pad_in(pin),
        .pad_out(p_out), .pad_oe_n(p_oen), .pad_weak_pu(p_wk), .pad_very_weak_pu(p_vw),
        .pad_ibuf_en(p_ib), .gpio_free(gfree), .gpio_count(gcnt));
    ppm_pad_model u_pads (.clock(clock), .pad_out(p_out), .pad_oe_n(p_oen),
        .pad_weak_pu(p_wk), .pad_very_weak_pu(p_vw), .ext_en(ext_en), .ext_val(ext_val),
        .pad_in(pin));
    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nx
    task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic end_of_test();
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test
    task automatic acc(input logic [7:0] a, input logic w, r, m, input logic [7:0] d);
        @(posedge clock);
        req <= {a, w, r, m, d};
        @(posedge clock);
        req.wr <= 1'b0;
        req.rd <= 1'b0;
    endtask : acc
    task automatic rd_exp(input logic [7:0] a, input logic m, input logic [7:0] e);
        expq.push_back(e);
        acc(a, 1'b0, 1'b1, m, 8'h00);
    endtask : rd_exp
    // Read data lands the cycle after the strobe and holds until the next read.
    always @(posedge clock) begin
        rd_d <= req.rd;
        if (rd_d && expq.size() > 0)
            chk(rdata, expq.pop_front());
    end
    initial begin
        #300000;
        failures++;
        end_of_test();
    end
    initial begin
        for (int f = 0; f < 2; f++) begin
            nrst <= 1'b0;
            fuse <= f[0];
            repeat (10) @(posedge clock);
            nrst <= 1'b1;
            repeat (2) @(posedge clock);
            foreach (ra[i]) rd_exp(ra[i], 1'b0, f ? r1[i] : r0[i]);
            rd_exp(8'h90, 1'b1, 8'hff);
            chk(hit, 1'b1);
            rd_exp(8'h81, 1'b0, 8'h00);
            @(posedge clock);
            #1 chk(hit, 1'b0);
            $display("test reset fuse %0d done", f);
        end
        for (int i = 0; i < 8; i++) begin
            acc(8'he6, 1'b1, 1'b0, 1'b0, {8{i[2]}});
            acc(8'he7, 1'b1, 1'b0, 1'b0, {8{i[1]}});
            acc(8'h90, 1'b1, 1'b0, 1'b0, {8{i[0]}});
            repeat (8) @(posedge clock);
            #1 chk({p_out[10], p_oen[10], p_wk[10], p_vw[10]}, mx[i]);
        end
        acc(8'he6, 1'b1, 1'b0, 1'b0, 8'h00);
        acc(8'he7, 1'b1, 1'b0, 1'b0, 8'h00);
        acc(8'h90, 1'b1, 1'b0, 1'b0, 8'h00);
        acc(8'h90, 1'b1, 1'b0, 1'b0, 8'hff);
        @(posedge clock);
        #1 chk({p_out[10], p_oen[10]}, 2'b10);
        @(posedge clock);
        #1 chk({p_out[10], p_oen[10]}, 2'b01);
        ext_en[10] <= 1'b1;
        repeat (6) @(posedge clock);
        #1 chk({p_wk[10], p_vw[10]}, 2'b01);
        gdis <= 1'b1;
        repeat (3) @(posedge clock);
        #1 chk(p_vw[10], 1'b0);
        gdis <= 1'b0;
        alt[10] <= 1'b0;
        repeat (3) @(posedge clock);
        #1 chk({p_oen[10], p_vw[10]}, 2'b00);
        alt[10] <= 1'b1;
        $display("test pin modes done");
        acc(8'he6, 1'b1, 1'b0, 1'b0, 8'hff);
        ext_en <= 40'hc0_0c00_ff00;
        for (int k = 0; k < 4; k++) begin
            lfsr = nx(lfsr);
            ext_val[15:8] <= lfsr[7:0];
            v = lfsr[7:0];
            repeat (6) @(posedge clock);
            rd_exp(8'h90, 1'b0, v);
            lfsr = nx(lfsr);
            acc(8'h90, 1'b1, 1'b0, 1'b0, lfsr[7:0]);
            rd_exp(8'h90, 1'b1, lfsr[7:0]);
            #1 chk(alt_in[15:8], v & lfsr[7:0]);
        end
        $display("test reads done");
        pd <= 1'b1;
        kbe <= 8'h04;
        repeat (3) @(posedge clock);
        #1 chk(p_ib, 40'hc0_0c00_0400);
        pd <= 1'b0;
        repeat (3) @(posedge clock);
        #1 chk(p_ib, {40{1'b1}});
        osc2 <= 1'b1;
        osc1 <= 1'b0;
        rc <= 1'b0;
        repeat (3) @(posedge clock);
        #1 chk(gfree, 40'h3f_ffff_fcff);
        chk(gcnt, 40'd36);
        osc2 <= 1'b0;
        rc <= 1'b1;
        repeat (3) @(posedge clock);
        #1 chk(gfree, {40{1'b1}});
        chk(gcnt, 40'd40);
        $display("test power and clock pins done");
        repeat (3) @(posedge clock);
        end_of_test();
    end
endmodule : tb
`default_nettype wire

// [rtl/ppm_pin_cell.sv]
// One pin's driver control: mode decode and pull-up/pull-down selection.
`timescale 1ns/1ps
`default_nettype none

module ppm_pin_cell (
    // Clock and reset
    input  wire logic          clock,
    input  wire logic          nrst,
    // Configuration
    input  wire logic          pin_mode_select_a,
    input  wire logic          pin_mode_select_b,
    input  wire logic          latch,
    input  wire logic          alt_out,
    input  wire logic          sensed,
    input  wire logic          pullup_global_disable,
    input  wire logic          claimed,
    // Drive
    output var ppm_pkg::ppm_drive_t drive
);

    logic               out_bit;
    logic               out_prev_r;
    ppm_pkg::ppm_drive_t drive_nxt;

    // Alternate functions are ANDed with the latch.
    assign out_bit = latch & alt_out;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            out_prev_r <= 1'b1;
        end else begin
            out_prev_r <= out_bit;
        end
    end

    always_comb begin
        drive_nxt = '0;
        if (!claimed) begin
            case ({pin_mode_select_a, pin_mode_select_b})
                2'b00: begin
                    drive_nxt.very_weak_pu = out_bit & ~pullup_global_disable;
                    drive_nxt.weak_pu      = out_bit & sensed;
                    drive_nxt.strong_pu    = out_bit & ~out_prev_r;
                    drive_nxt.pull_dn      = ~out_bit;
                end
                2'b01: begin
                    drive_nxt.strong_pu = out_bit;
                    drive_nxt.pull_dn   = ~out_bit;
                end
                2'b11: begin
                    drive_nxt.pull_dn = ~out_bit;
                end
                default: begin
                    drive_nxt = '0;
                end
            endcase
        end
    end

    // Mode decode follows the two select bits.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            drive <= '0;
        end else begin
            drive <= drive_nxt;
        end
    end

    AST_STRONG_ONE_CYCLE: assert property (@(posedge clock) disable iff (!nrst)
        drive.strong_pu && $past(!pin_mode_select_a && !pin_mode_select_b)
        |=> !drive.strong_pu || $past(pin_mode_select_b && !pin_mode_select_a))
        else $error("strong pull-up held past one cycle in quasi mode");

    AST_INPUT_TRISTATE: assert property (@(posedge clock) disable iff (!nrst)
        (pin_mode_select_a && !pin_mode_select_b) |=> drive == '0)
        else $error("input-only pin still driven");

    AST_OD_NO_PULLUP: assert property (@(posedge clock) disable iff (!nrst)
        (pin_mode_select_a && pin_mode_select_b && !claimed)
        |=> !drive.strong_pu && !drive.weak_pu && drive.pull_dn == !$past(out_bit))
        else $error("open-drain pin drive wrong");

    AST_QUASI_VWEAK: assert property (@(posedge clock) disable iff (!nrst)
        (!pin_mode_select_a && !pin_mode_select_b && !claimed)
        |=> drive.very_weak_pu == ($past(out_bit) && !$past(pullup_global_disable)))
        else $error("very weak pull-up does not follow latch");

endmodule : ppm_pin_cell

`default_nettype wire

// [rtl/ppm_pkg.sv]
// Shared constants and types for the port pin mode control block.
package ppm_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int PORTS = 5;
    localparam int PINS  = 40;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] P0_DATA_ADDR = 8'h80;
    localparam logic [7:0] P1_DATA_ADDR = 8'h90;
    localparam logic [7:0] P2_DATA_ADDR = 8'ha0;
    localparam logic [7:0] P3_DATA_ADDR = 8'hb0;
    localparam logic [7:0] P4_DATA_ADDR = 8'hc0;
    localparam logic [7:0] P0_SEL_A_ADDR = 8'hd4;
    localparam logic [7:0] P0_SEL_B_ADDR = 8'hd5;
    localparam logic [7:0] P1_SEL_A_ADDR = 8'he6;
    localparam logic [7:0] P1_SEL_B_ADDR = 8'he7;
    localparam logic [7:0] P2_SEL_A_ADDR = 8'hd6;
    localparam logic [7:0] P2_SEL_B_ADDR = 8'hd7;
    localparam logic [7:0] P3_SEL_A_ADDR = 8'hde;
    localparam logic [7:0] P3_SEL_B_ADDR = 8'hcf;
    localparam logic [7:0] P4_SEL_A_ADDR = 8'hbe;
    localparam logic [7:0] P4_SEL_B_ADDR = 8'hbf;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] LATCH_RST      = 8'hff;
    localparam logic [7:0] P0_SEL_RST     = 8'hff;
    localparam logic [7:0] TRI_SEL_A_RST  = 8'hff;
    localparam logic [7:0] QUASI_SEL_RST  = 8'h00;
    localparam logic [7:0] P2_ANALOG_MASK = 8'hf0;
    localparam logic [7:0] P4_SEL_A_TRI   = 8'hc7;
    localparam logic [7:0] P4_SEL_A_QUASI = 8'h03;
    localparam logic [7:0] P4_SEL_B_RST   = 8'h03;

    // ------------------------------------------------------------
    // Pin indices (port * 8 + bit)
    // ------------------------------------------------------------
    localparam int PIN_EXT_INT_ZERO = 26;
    localparam int PIN_EXT_INT_ONE  = 27;
    localparam int PIN_CRYSTAL_IN   = 38;
    localparam int PIN_CRYSTAL_OUT  = 39;
    localparam int PIN_OSC2_IN      = 8;
    localparam int PIN_OSC2_OUT     = 9;
    localparam int PORT1_BASE       = 8;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic       rmw;
        logic [7:0] wdata;
    } ppm_sfr_req_t;

    typedef struct packed {
        logic strong_pu;
        logic weak_pu;
        logic very_weak_pu;
        logic pull_dn;
    } ppm_drive_t;

endpackage : ppm_pkg

// [rtl/ppm_port_ctrl.sv]
// Five 8-bit ports: special-function registers, pin sensing and pin drive.
`timescale 1ns/1ps
`default_nettype none

module ppm_port_ctrl (
    // Clock and reset
    input  wire logic                 clock,
    input  wire logic                 nrst,
    // Register port
    input  wire ppm_pkg::ppm_sfr_req_t sfr_req,
    output logic [7:0]                sfr_rdata,
    output logic                      sfr_hit,
    // Device control levels
    input  wire logic                 tristate_fuse,
    input  wire logic                 pullup_global_disable,
    input  wire logic                 power_down,
    input  wire logic [7:0]           keyboard_enable,
    input  wire logic                 first_osc_enable,
    input  wire logic                 first_osc_rc_mode,
    input  wire logic                 second_osc_enable,
    // Peripheral alternate functions
    input  wire logic [39:0]          alt_out,
    output logic [39:0]               alt_in,
    // Pads
    input  wire logic [39:0]          pad_in,
    output logic [39:0]               pad_out,
    output logic [39:0]               pad_oe_n,
    output logic [39:0]               pad_weak_pu,
    output logic [39:0]               pad_very_weak_pu,
    output logic [39:0]               pad_ibuf_en,
    // Pin availability
    output logic [39:0]               gpio_free,
    output logic [5:0]                gpio_count
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0]  latch_r [0:4];
    logic [7:0]  sel_a_r [0:4];
    logic [7:0]  sel_b_r [0:4];
    logic        init_r;
    logic        fuse;
    logic [39:0] latch_flat;
    logic [39:0] sel_a_flat;
    logic [39:0] sel_b_flat;

    // Address decode: port index and register kind.
    logic [2:0]  dec_port;
    logic [1:0]  dec_kind;
    logic        dec_hit;

    always_comb begin
        dec_hit  = 1'b1;
        dec_port = 3'h0;
        dec_kind = 2'h0;
        case (sfr_req.addr)
            ppm_pkg::P0_DATA_ADDR:  begin dec_port = 3'h0; dec_kind = 2'h0; end
            ppm_pkg::P1_DATA_ADDR:  begin dec_port = 3'h1; dec_kind = 2'h0; end
            ppm_pkg::P2_DATA_ADDR:  begin dec_port = 3'h2; dec_kind = 2'h0; end
            ppm_pkg::P3_DATA_ADDR:  begin dec_port = 3'h3; dec_kind = 2'h0; end
            ppm_pkg::P4_DATA_ADDR:  begin dec_port = 3'h4; dec_kind = 2'h0; end
            ppm_pkg::P0_SEL_A_ADDR: begin dec_port = 3'h0; dec_kind = 2'h1; end
            ppm_pkg::P1_SEL_A_ADDR: begin dec_port = 3'h1; dec_kind = 2'h1; end
            ppm_pkg::P2_SEL_A_ADDR: begin dec_port = 3'h2; dec_kind = 2'h1; end
            ppm_pkg::P3_SEL_A_ADDR: begin dec_port = 3'h3; dec_kind = 2'h1; end
            ppm_pkg::P4_SEL_A_ADDR: begin dec_port = 3'h4; dec_kind = 2'h1; end
            ppm_pkg::P0_SEL_B_ADDR: begin dec_port = 3'h0; dec_kind = 2'h2; end
            ppm_pkg::P1_SEL_B_ADDR: begin dec_port = 3'h1; dec_kind = 2'h2; end
            ppm_pkg::P2_SEL_B_ADDR: begin dec_port = 3'h2; dec_kind = 2'h2; end
            ppm_pkg::P3_SEL_B_ADDR: begin dec_port = 3'h3; dec_kind = 2'h2; end
            ppm_pkg::P4_SEL_B_ADDR: begin dec_port = 3'h4; dec_kind = 2'h2; end
            default:                dec_hit = 1'b0;
        endcase
    end

    assign sfr_hit = dec_hit;

    // ------------------------------------------------------------
    // Reset-time mode loading
    // ------------------------------------------------------------
    // The fuse is a static level; it is only looked at in the first cycle
    // after reset release, so the asynchronous reset loads constants only.
    assign fuse = tristate_fuse;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            init_r <= 1'b1;
        end else begin
            init_r <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            for (int p = 0; p < ppm_pkg::PORTS; p++) begin
                latch_r[p] <= ppm_pkg::LATCH_RST;
            end
        end else if (sfr_req.wr && dec_hit && dec_kind == 2'h0 && !init_r) begin
            latch_r[dec_port] <= sfr_req.wdata;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sel_a_r[0] <= ppm_pkg::P0_SEL_RST;
            sel_a_r[1] <= ppm_pkg::TRI_SEL_A_RST;
            sel_a_r[2] <= ppm_pkg::TRI_SEL_A_RST;
            sel_a_r[3] <= ppm_pkg::TRI_SEL_A_RST;
            sel_a_r[4] <= ppm_pkg::P4_SEL_A_TRI;
        end else if (init_r) begin
            sel_a_r[0] <= ppm_pkg::P0_SEL_RST;
            sel_a_r[1] <= fuse ? ppm_pkg::TRI_SEL_A_RST : ppm_pkg::QUASI_SEL_RST;
            sel_a_r[2] <= fuse ? ppm_pkg::TRI_SEL_A_RST : ppm_pkg::P2_ANALOG_MASK;
            sel_a_r[3] <= fuse ? ppm_pkg::TRI_SEL_A_RST : ppm_pkg::QUASI_SEL_RST;
            sel_a_r[4] <= fuse ? ppm_pkg::P4_SEL_A_TRI : ppm_pkg::P4_SEL_A_QUASI;
        end else if (sfr_req.wr && dec_hit && dec_kind == 2'h1) begin
            sel_a_r[dec_port] <= sfr_req.wdata;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sel_b_r[0] <= ppm_pkg::P0_SEL_RST;
            sel_b_r[1] <= ppm_pkg::QUASI_SEL_RST;
            sel_b_r[2] <= ppm_pkg::QUASI_SEL_RST;
            sel_b_r[3] <= ppm_pkg::QUASI_SEL_RST;
            sel_b_r[4] <= ppm_pkg::P4_SEL_B_RST;
        end else if (sfr_req.wr && dec_hit && dec_kind == 2'h2 && !init_r) begin
            sel_b_r[dec_port] <= sfr_req.wdata;
        end
    end

    // ------------------------------------------------------------
    // Pin sensing
    // ------------------------------------------------------------
    logic [39:0] sync1_r;
    logic [39:0] sync2_r;
    logic [39:0] sync3_r;
    logic [39:0] level_r;
    logic [39:0] sensed;

    // Three stages, and a change is taken only when stages two and three
    // agree; this rejects a single-cycle glitch that slips past the first.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sync1_r <= '0;
            sync2_r <= '0;
            sync3_r <= '0;
        end else begin
            sync1_r <= pad_in;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            level_r <= '0;
        end else begin
            level_r <= (sync2_r & sync3_r) | (level_r & (sync2_r | sync3_r));
        end
    end

    // ------------------------------------------------------------
    // Input buffer gating in power-down
    // ------------------------------------------------------------
    logic [39:0] awake_mask;

    always_comb begin
        awake_mask = '0;
        awake_mask[ppm_pkg::PIN_EXT_INT_ZERO] = 1'b1;
        awake_mask[ppm_pkg::PIN_EXT_INT_ONE]  = 1'b1;
        awake_mask[ppm_pkg::PIN_CRYSTAL_IN]   = 1'b1;
        awake_mask[ppm_pkg::PIN_CRYSTAL_OUT]  = 1'b1;
        awake_mask[ppm_pkg::PORT1_BASE +: 8]  = keyboard_enable;
    end

    // Pins left floating while their buffer stays awake will draw current;
    // the board or software must prevent that.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pad_ibuf_en <= '1;
        end else begin
            pad_ibuf_en <= power_down ? awake_mask : '1;
        end
    end

    assign sensed = level_r & pad_ibuf_en;

    // ------------------------------------------------------------
    // Oscillator pin ownership
    // ------------------------------------------------------------
    logic [39:0] claimed;

    always_comb begin
        claimed = '0;
        claimed[ppm_pkg::PIN_CRYSTAL_IN]  = !first_osc_rc_mode;
        claimed[ppm_pkg::PIN_CRYSTAL_OUT] = !first_osc_rc_mode;
        claimed[ppm_pkg::PIN_OSC2_IN]     = second_osc_enable;
        claimed[ppm_pkg::PIN_OSC2_OUT]    = second_osc_enable;
    end

    // The first oscillator's enable deliberately has no say here.
    logic unused_osc;
    assign unused_osc = first_osc_enable;

    logic [5:0] free_cnt;

    always_comb begin
        free_cnt = 6'h00;
        for (int i = 0; i < ppm_pkg::PINS; i++) begin
            free_cnt = free_cnt + {5'h00, !claimed[i]};
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            gpio_free  <= '0;
            gpio_count <= 6'h00;
        end else begin
            gpio_free  <= ~claimed;
            gpio_count <= free_cnt;
        end
    end

    // ------------------------------------------------------------
    // Per-pin drive
    // ------------------------------------------------------------
    ppm_pkg::ppm_drive_t drive [0:39];

    genvar g;
    generate
        for (g = 0; g < ppm_pkg::PINS; g++) begin : g_pin
            assign latch_flat[g] = latch_r[g / 8][g % 8];
            assign sel_a_flat[g] = sel_a_r[g / 8][g % 8];
            assign sel_b_flat[g] = sel_b_r[g / 8][g % 8];

            ppm_pin_cell u_cell (
                .clock                 (clock),
                .nrst                  (nrst),
                .pin_mode_select_a     (sel_a_flat[g]),
                .pin_mode_select_b     (sel_b_flat[g]),
                .latch                 (latch_flat[g]),
                .alt_out               (alt_out[g]),
                .sensed                (sensed[g]),
                .pullup_global_disable (pullup_global_disable),
                .claimed               (claimed[g]),
                .drive                 (drive[g])
            );

            assign pad_out[g]          = drive[g].strong_pu;
            assign pad_oe_n[g]         = !(drive[g].strong_pu || drive[g].pull_dn);
            assign pad_weak_pu[g]      = drive[g].weak_pu;
            assign pad_very_weak_pu[g] = drive[g].very_weak_pu;
            assign alt_in[g]           = sensed[g] & latch_flat[g];
        end
    endgenerate

    // ------------------------------------------------------------
    // Register read
    // ------------------------------------------------------------
    logic [7:0] rd_nxt;
    logic [7:0] pin_byte;

    always_comb begin
        pin_byte = sensed[8 * dec_port +: 8];
        rd_nxt   = 8'h00;
        if (dec_hit) begin
            case (dec_kind)
                2'h0:    rd_nxt = sfr_req.rmw ? latch_r[dec_port] : pin_byte;
                2'h1:    rd_nxt = sel_a_r[dec_port];
                2'h2:    rd_nxt = sel_b_r[dec_port];
                default: rd_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_req.rd) begin
            sfr_rdata <= rd_nxt;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_FUSE_INIT: assert property (@(posedge clock) disable iff (!nrst)
        (init_r && fuse) |=> sel_a_r[1] == 8'hff && sel_b_r[1] == 8'h00
                           && sel_a_r[3] == 8'hff)
        else $error("fuse-enabled reset modes not input-only");

    AST_P0_OPEN_DRAIN: assert property (@(posedge clock) disable iff (!nrst)
        init_r |=> sel_a_r[0] == 8'hff && sel_b_r[0] == 8'hff)
        else $error("port 0 not open-drain after reset");

    AST_P4_FIXED_INIT: assert property (@(posedge clock) disable iff (!nrst)
        init_r |=> sel_a_r[4][5:4] == 2'b00 && sel_b_r[4][5:4] == 2'b00
                   && sel_a_r[4][1:0] == 2'b11 && sel_b_r[4][1:0] == 2'b11)
        else $error("port 4 fixed reset modes wrong");

    AST_PD_BUFFERS: assert property (@(posedge clock) disable iff (!nrst)
        power_down |=> !pad_ibuf_en[0] && pad_ibuf_en[ppm_pkg::PIN_EXT_INT_ZERO]
                       && pad_ibuf_en[ppm_pkg::PIN_CRYSTAL_OUT])
        else $error("power-down buffer gating wrong");

    AST_RMW_READ: assert property (@(posedge clock) disable iff (!nrst)
        (sfr_req.rd && sfr_req.rmw && sfr_req.addr == 8'h90)
        |=> sfr_rdata == $past(latch_r[1]))
        else $error("read-modify-write read did not return latch");

    AST_SYNC_DELAY: assert property (@(posedge clock) disable iff (!nrst)
        $rose(sync3_r[0]) && sync2_r[0] |=> level_r[0])
        else $error("agreed pin level not taken");

endmodule : ppm_port_ctrl

`default_nettype wire
